// ==== core/ctic_pkg.sv ====
// constants for the channel threshold and inhibit configuration bank
package ctic_pkg;
   // =========================================================
   // register port
   localparam int unsigned CTIC_DATA_W = 32;
   localparam int unsigned CTIC_ADDR_W = 4;
   localparam int unsigned CTIC_IDX_W = 3;
   localparam int unsigned CTIC_WORDS = 8;
   localparam logic [CTIC_ADDR_W-1:0] CTIC_IDX_THR0 = 4'h0;
   localparam logic [CTIC_ADDR_W-1:0] CTIC_IDX_INH_LO0 = 4'h4;
   localparam logic [CTIC_ADDR_W-1:0] CTIC_IDX_INH_HI0 = 4'h6;
   localparam logic [CTIC_ADDR_W-1:0] CTIC_IDX_LAST = 4'h7;
   localparam logic [CTIC_DATA_W-1:0] CTIC_WORD_RST = 32'h0000_0000;
   localparam logic [CTIC_DATA_W-1:0] CTIC_UNMAPPED = 32'h0000_0000;
   // =========================================================
   // field layout
   localparam int unsigned CTIC_THR_BITS = 128;
   localparam int unsigned CTIC_INH_BITS = 64;
   localparam int unsigned CTIC_CODE_W = 4;
   localparam int unsigned CTIC_NUM_CH = 64;
   localparam int unsigned CTIC_HALF_CH = 32;
   localparam int unsigned CTIC_QUARTER_CH = 16;
   localparam int unsigned CTIC_GEN_BIT = 0;
   localparam int unsigned CTIC_TRIG_BIT = 1;
   localparam int unsigned CTIC_PAIR_W = 2;
   localparam int unsigned CTIC_LO_HALF_BASE = 32;
   localparam logic [CTIC_NUM_CH-1:0] CTIC_INH_RST = 64'h0;
endpackage : ctic_pkg

// ==== core/ctic_top.sv ====
// channel threshold and inhibit configuration bank, channels 33-64 thresholds
`timescale 1ns/1ns
`default_nettype none
// =========================================================
// Function
// - a 128-bit register holds one 4-bit threshold code per channel 33..64.
// - codes ascend by channel; channel 33 at bits 0-3, channel 64 at 124-127.
// - two 64-bit inhibit registers, channels 1..32 and 33..64, two bits each.
// - lower-half register descends: ch32 at 0-1..ch17 at 30-31, ch16 at 32-33..ch1.
// - upper-half register ascends: ch33 at 0-1, ch49 at 32-33, ch64 at 62-63.
// - lower bit of a pair is general inhibit, upper bit is trigger inhibit.
// - inhibit excludes from trigger building only, or trigger building plus hit register.
module ctic_top (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // register port
   input wire logic [ctic_pkg::CTIC_ADDR_W-1:0] reg_addr,
   input wire logic [ctic_pkg::CTIC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ctic_pkg::CTIC_DATA_W-1:0] reg_rdata,
   // threshold dac codes, channel 33 in the low nibble
   output logic [ctic_pkg::CTIC_THR_BITS-1:0] thr_code_upper,
   // per channel controls, bit n is channel n+1
   output logic [ctic_pkg::CTIC_NUM_CH-1:0] chan_inhibit,
   output logic [ctic_pkg::CTIC_NUM_CH-1:0] trig_inhibit,
   output logic [ctic_pkg::CTIC_NUM_CH-1:0] trig_build_excl,
   output logic [ctic_pkg::CTIC_NUM_CH-1:0] hit_reg_excl
);
   // =========================================================
   // bit position of a channel's pair in its inhibit register
   function automatic int unsigned lo_half_pos(input int unsigned ch);
      if (ch <= ctic_pkg::CTIC_QUARTER_CH) begin
         return ctic_pkg::CTIC_LO_HALF_BASE
                + ctic_pkg::CTIC_PAIR_W * (ctic_pkg::CTIC_QUARTER_CH - ch);
      end
      return ctic_pkg::CTIC_PAIR_W * (ctic_pkg::CTIC_HALF_CH - ch);
   endfunction : lo_half_pos

   function automatic int unsigned hi_half_pos(input int unsigned ch);
      return ctic_pkg::CTIC_PAIR_W * (ch - ctic_pkg::CTIC_HALF_CH - 1);
   endfunction : hi_half_pos

   // =========================================================
   // address decode and storage
   logic mapped;
   logic [ctic_pkg::CTIC_WORDS*ctic_pkg::CTIC_DATA_W-1:0] all_words;
   logic [ctic_pkg::CTIC_THR_BITS-1:0] thr_field;
   logic [ctic_pkg::CTIC_INH_BITS-1:0] inh_lo_field;
   logic [ctic_pkg::CTIC_INH_BITS-1:0] inh_hi_field;

   // unmapped writes are dropped, unmapped reads answer zero
   assign mapped = (reg_addr <= ctic_pkg::CTIC_IDX_LAST);

   ctic_word_mem u_mem (
      .clock(clock),
      .arst_n(arst_n),
      .wr_en(reg_wr && mapped),
      .wr_idx(reg_addr[ctic_pkg::CTIC_IDX_W-1:0]),
      .wr_data(reg_wdata),
      .rd_en(reg_rd && mapped),
      .rd_idx(reg_addr[ctic_pkg::CTIC_IDX_W-1:0]),
      .rd_data(reg_rdata),
      .all_words(all_words)
   );

   assign thr_field = all_words[ctic_pkg::CTIC_IDX_THR0*ctic_pkg::CTIC_DATA_W
                                +: ctic_pkg::CTIC_THR_BITS];
   assign inh_lo_field = all_words[ctic_pkg::CTIC_IDX_INH_LO0*ctic_pkg::CTIC_DATA_W
                                   +: ctic_pkg::CTIC_INH_BITS];
   assign inh_hi_field = all_words[ctic_pkg::CTIC_IDX_INH_HI0*ctic_pkg::CTIC_DATA_W
                                   +: ctic_pkg::CTIC_INH_BITS];

   // =========================================================
   // decoded outputs, registered so the analog side sees clean levels
   typedef struct packed {
      logic [ctic_pkg::CTIC_THR_BITS-1:0] thr;
      logic [ctic_pkg::CTIC_NUM_CH-1:0] gen;
      logic [ctic_pkg::CTIC_NUM_CH-1:0] trig;
      logic [ctic_pkg::CTIC_NUM_CH-1:0] build;
      logic [ctic_pkg::CTIC_NUM_CH-1:0] hit;
   } ctic_top_s;

   ctic_top_s state;
   ctic_top_s next_state;

   always_comb begin
      next_state = state;
      // word 0 low nibble is channel 33, ascending upward
      next_state.thr = thr_field;
      for (int unsigned ch = 1; ch <= ctic_pkg::CTIC_NUM_CH; ch++) begin
         if (ch <= ctic_pkg::CTIC_HALF_CH) begin
            next_state.gen[ch-1] = inh_lo_field[lo_half_pos(ch) + ctic_pkg::CTIC_GEN_BIT];
            next_state.trig[ch-1] = inh_lo_field[lo_half_pos(ch) + ctic_pkg::CTIC_TRIG_BIT];
         end else begin
            next_state.gen[ch-1] = inh_hi_field[hi_half_pos(ch) + ctic_pkg::CTIC_GEN_BIT];
            next_state.trig[ch-1] = inh_hi_field[hi_half_pos(ch) + ctic_pkg::CTIC_TRIG_BIT];
         end
      end
      // general inhibit drops the channel from the whole trigger data
      next_state.build = next_state.gen | next_state.trig;
      next_state.hit = next_state.gen;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state.thr <= '0;
         state.gen <= ctic_pkg::CTIC_INH_RST;
         state.trig <= ctic_pkg::CTIC_INH_RST;
         state.build <= ctic_pkg::CTIC_INH_RST;
         state.hit <= ctic_pkg::CTIC_INH_RST;
      end else begin
         state <= next_state;
      end
   end

   assign thr_code_upper = state.thr;
   assign chan_inhibit = state.gen;
   assign trig_inhibit = state.trig;
   assign trig_build_excl = state.build;
   assign hit_reg_excl = state.hit;
endmodule : ctic_top
`default_nettype wire

// ==== core/ctic_word_mem.sv ====
// word store for the configuration bank, flat view plus registered read port
`timescale 1ns/1ns
`default_nettype none
module ctic_word_mem (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // write side
   input wire logic wr_en,
   input wire logic [ctic_pkg::CTIC_IDX_W-1:0] wr_idx,
   input wire logic [ctic_pkg::CTIC_DATA_W-1:0] wr_data,
   // read side
   input wire logic rd_en,
   input wire logic [ctic_pkg::CTIC_IDX_W-1:0] rd_idx,
   output logic [ctic_pkg::CTIC_DATA_W-1:0] rd_data,
   // all words, word k at bits 32k up
   output logic [ctic_pkg::CTIC_WORDS*ctic_pkg::CTIC_DATA_W-1:0] all_words
);
   // =========================================================
   // state
   typedef struct packed {
      logic [ctic_pkg::CTIC_WORDS-1:0][ctic_pkg::CTIC_DATA_W-1:0] words;
      logic [ctic_pkg::CTIC_DATA_W-1:0] rd_data;
   } ctic_mem_s;

   ctic_mem_s state;
   ctic_mem_s next_state;

   always_comb begin
      next_state = state;
      if (wr_en) begin
         next_state.words[wr_idx] = wr_data;
      end
      // read data stand one cycle only, zero otherwise
      next_state.rd_data = rd_en ? state.words[rd_idx] : ctic_pkg::CTIC_UNMAPPED;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state.words <= {ctic_pkg::CTIC_WORDS{ctic_pkg::CTIC_WORD_RST}};
         state.rd_data <= ctic_pkg::CTIC_UNMAPPED;
      end else begin
         state <= next_state;
      end
   end

   assign rd_data = state.rd_data;
   assign all_words = state.words;
endmodule : ctic_word_mem
`default_nettype wire

// ==== test/ctic_top_monitor.sv ====
// port assertions for the threshold and inhibit bank
`timescale 1ns/1ns
`default_nettype none
module ctic_top_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // decoded outputs
   input wire logic [127:0] thr_code_upper,
   input wire logic [63:0] chan_inhibit,
   input wire logic [63:0] trig_inhibit,
   input wire logic [63:0] trig_build_excl,
   input wire logic [63:0] hit_reg_excl
);
   // =====
   // outputs lag a write by two edges
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   chk_thr_low_word: assert property ($past(reg_wr && reg_addr == 4'h0, 2)
      |-> thr_code_upper[31:0] == $past(reg_wdata, 2)) else $error("thr word0");
   chk_thr_top_word: assert property ($past(reg_wr && reg_addr == 4'h3, 2)
      |-> thr_code_upper[127:96] == $past(reg_wdata, 2)) else $error("thr word3");
   chk_inh_lo_first: assert property ($past(reg_wr && reg_addr == 4'h4, 2) |->
      {trig_inhibit[31], chan_inhibit[31], trig_inhibit[16], chan_inhibit[16]}
      == {$past(reg_wdata[1:0], 2), $past(reg_wdata[31:30], 2)}) else $error("inh word4");
   chk_inh_lo_second: assert property ($past(reg_wr && reg_addr == 4'h5, 2) |->
      {trig_inhibit[15], chan_inhibit[15], trig_inhibit[0], chan_inhibit[0]}
      == {$past(reg_wdata[1:0], 2), $past(reg_wdata[31:30], 2)}) else $error("inh word5");
   chk_inh_hi_first: assert property ($past(reg_wr && reg_addr == 4'h6, 2) |->
      {trig_inhibit[32], chan_inhibit[32]} == $past(reg_wdata[1:0], 2)) else $error("inh word6");
   chk_inh_hi_second: assert property ($past(reg_wr && reg_addr == 4'h7, 2) |->
      {trig_inhibit[63], chan_inhibit[48]} == {$past(reg_wdata[31], 2), $past(reg_wdata[0], 2)})
      else $error("inh word7");
   chk_hit_gen_only: assert property (hit_reg_excl == chan_inhibit)
      else $error("hit excl");
   chk_build_any_bit: assert property (trig_build_excl == (chan_inhibit | trig_inhibit))
      else $error("build excl");
   // read data stand only in the cycle after a read strobe
   chk_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("rdata not zero when idle");
   chk_rdata_unmapped_zero: assert property ($past(reg_rd && reg_addr > 4'h7)
      |-> reg_rdata == 32'h0) else $error("rdata not zero for unmapped word");
endmodule : ctic_top_monitor
`default_nettype wire

// ==== test/ctic_top_tb_top.sv ====
// self-checking bench for the threshold and inhibit bank
`timescale 1ns/1ns
`default_nettype none
module ctic_top_tb_top;
   // =====
   logic clock, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, lfsr = 32'he1593f35;
   logic [127:0] thr_code_upper;
   logic [63:0] chan_inhibit, trig_inhibit, trig_build_excl, hit_reg_excl, lo, hi, gen, trg;
   logic [31:0] mirror [8] = '{default: 32'h0};
   logic [31:0] exp_q [$];
   int error_cnt, num_checks;
   ctic_top DUT (
      .clock(clock),
      .arst_n(arst_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .thr_code_upper(thr_code_upper),
      .chan_inhibit(chan_inhibit),
      .trig_inhibit(trig_inhibit),
      .trig_build_excl(trig_build_excl),
      .hit_reg_excl(hit_reg_excl)
   );
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // strobes rewritten every cycle, so none is set twice in one step
   task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      if (w && a < 4'h8) mirror[a[2:0]] = d;
      if (r) exp_q.push_back(a < 4'h8 ? mirror[a[2:0]] : 32'h0);
      @(posedge clock);
   endtask : bus
   always @(posedge clock) rd_pend <= reg_rd;
   always @(negedge clock) if (rd_pend) cmp(reg_rdata, exp_q.pop_front());
   task automatic check_outputs;
      repeat (2) bus(1'b0, 1'b0, 4'h0, 32'h0);
      @(negedge clock);
      lo = {mirror[5], mirror[4]};
      hi = {mirror[7], mirror[6]};
      for (int c = 0; c < 32; c++) begin
         {trg[c], gen[c]} = lo[62-2*c +: 2];
         {trg[32+c], gen[32+c]} = hi[2*c +: 2];
      end
      cmp(thr_code_upper, {mirror[3], mirror[2], mirror[1], mirror[0]});
      cmp(chan_inhibit, gen);
      cmp(trig_inhibit, trg);
      cmp(hit_reg_excl, gen);
      cmp(trig_build_excl, gen | trg);
      @(posedge clock);
   endtask : check_outputs
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      check_outputs();
      $display("test reset done");
      // words 8 and 9 are unmapped; 9 would alias word 1 on a short decode
      for (int r = 0; r < 6; r++) begin
         for (int a = 0; a < 10; a++) begin
            lfsr = lfsr_next(lfsr);
            bus(1'b1, 1'b0, 4'(a), lfsr);
         end
         for (int a = 9; a >= 0; a--) bus(1'b0, 1'b1, 4'(a), 32'h0);
         check_outputs();
         $display("test round %0d done", r);
      end
      // mid-run reset must clear every stored word, not only the first boot
      arst_n <= 1'b0;
      mirror = '{default: 32'h0};
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      check_outputs();
      $display("test mid-run reset done");
      summarize();
   end
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
endmodule : ctic_top_tb_top
bind ctic_top ctic_top_monitor u_mon (
   .clock(clock),
   .arst_n(arst_n),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .thr_code_upper(thr_code_upper),
   .chan_inhibit(chan_inhibit),
   .trig_inhibit(trig_inhibit),
   .trig_build_excl(trig_build_excl),
   .hit_reg_excl(hit_reg_excl)
);
`default_nettype wire
